// *** verilog/clock_timer_regs.svh ***
// register indices, field positions, reset values and timing figures of the clock timer
`ifndef CLOCK_TIMER_REGS_SVH
`define CLOCK_TIMER_REGS_SVH

// register indices; byte address is four times the index
`define CT_IDX_TAP_DATA 10'h0e3
`define CT_IDX_IRQ_ENABLE 10'h0eb
`define CT_IDX_EVENT_FLAGS 10'h0ef
`define CT_IDX_RESTART 10'h0f9
`define CT_ADDR_W 12

// field positions
`define CT_TAP_LSB 3
`define CT_TAP_MSB 6
`define CT_TAP32_BIT 2
`define CT_TAP8_BIT 4
`define CT_TAP2_BIT 6
`define CT_EVT_32HZ 0
`define CT_EVT_8HZ 1
`define CT_EVT_2HZ 2
`define CT_RESTART_BIT 0

// reset values
`define CT_COUNT_RST 7'h00
`define CT_ENABLE_RST 3'h0
`define CT_FLAGS_RST 3'h0

// timing: source tick rate and divider length
`define CT_SRC_HZ 256
`define CT_DIV_BITS 7

`endif

// *** verilog/clock_timer_pkg.sv ***
// types shared by the clock timer design files
`default_nettype none
package clock_timer_pkg;
  typedef logic [2:0] evt_t;
  typedef logic [6:0] count_t;
  typedef enum logic [2:0] {
    sel_none,
    sel_tap,
    sel_enable,
    sel_flags,
    sel_restart
  } reg_sel_e;
endpackage : clock_timer_pkg
`default_nettype wire

// *** verilog/tap_divider.sv ***
// seven-stage binary divider of the clock timer with falling-edge event pulses
`timescale 1ns/1ps
`default_nettype none
`include "clock_timer_regs.svh"
module tap_divider
  import clock_timer_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic restart,
  // state
  output logic [6:0] count,
  output evt_t fall
);

  count_t count_q;
  count_t count_d;
  wire count_t count_inc = count_q + 7'h01;

  // restart beats a coincident tick; the counter resumes from zero at once
  assign count_d = restart ? `CT_COUNT_RST : (tick ? count_inc : count_q);

  // only counting edges raise events; a restart that drops a stage does not
  assign fall[`CT_EVT_32HZ] = tick & ~restart & count_q[`CT_TAP32_BIT] &
                              ~count_inc[`CT_TAP32_BIT];
  assign fall[`CT_EVT_8HZ] = tick & ~restart & count_q[`CT_TAP8_BIT] &
                             ~count_inc[`CT_TAP8_BIT];
  assign fall[`CT_EVT_2HZ] = tick & ~restart & count_q[`CT_TAP2_BIT] &
                             ~count_inc[`CT_TAP2_BIT];
  assign count = count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `CT_COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  property p_div_step;
    @(posedge pclk) disable iff (!presetn)
    (tick && !restart) |=> (count_q == count_t'($past(count_q) + 7'h01));
  endproperty
  a_div_step: assert property (p_div_step) else $error("divider did not advance on tick");

  property p_div_hold;
    @(posedge pclk) disable iff (!presetn)
    (!tick && !restart) |=> $stable(count_q);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider moved without tick");

  property p_fall_2hz;
    @(posedge pclk) disable iff (!presetn)
    fall[`CT_EVT_2HZ] |=> (count_q == `CT_COUNT_RST);
  endproperty
  a_fall_2hz: assert property (p_fall_2hz) else $error("2 Hz fall not at wrap");

endmodule : tap_divider
`default_nettype wire

// *** verilog/clock_timer_control.sv ***
// clock timer control: tick sync, divider, APB registers, events and interrupt
// Notes on behaviour
// - seven-bit divider on 256 Hz, top four taps
// - taps 16/8/4/2 Hz read as bits 0-3
// - writes to tap data change nothing
// - reset clears the tap data
// - enable bits 0-2 for 32/8/2 Hz
// - reset masks all three interrupts
// - flags show events; writes ignored
// - flag set on falling stage edge
// - flags set even while masked
// - reading flags returns then clears them
// - reset clears all event flags
// - restart write of one clears counter
// - restart bit reads zero always
// - unused bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "clock_timer_regs.svh"
module clock_timer_control
  import clock_timer_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // 256 Hz prescaler tap, asynchronous to pclk
  input wire logic src_256hz,
  // interrupt request to the processor
  output logic timer_irq
);

  // ------------------------------------------------------------ tick sync
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic src_level_q;
  logic src_level_d;
  wire logic src_agree = (sync2_q == sync3_q);
  wire logic tick = src_agree & sync3_q & ~src_level_q;

  // a change only counts once the last two stages agree, so a glitch is filtered
  assign src_level_d = src_agree ? sync3_q : src_level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      src_level_q <= 1'b0;
    end else begin
      sync1_q <= src_256hz;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      src_level_q <= src_level_d;
    end
  end

  // ------------------------------------------------------------ address decode
  wire logic [9:0] reg_idx = paddr[11:2];
  wire logic word_ok = (paddr[1:0] == 2'b00);
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable & pready;
  wire logic acc_wr = access & pwrite;
  wire logic acc_rd = access & ~pwrite;
  reg_sel_e sel;

  assign sel = !word_ok ? sel_none :
               (reg_idx == `CT_IDX_TAP_DATA) ? sel_tap :
               (reg_idx == `CT_IDX_IRQ_ENABLE) ? sel_enable :
               (reg_idx == `CT_IDX_EVENT_FLAGS) ? sel_flags :
               (reg_idx == `CT_IDX_RESTART) ? sel_restart : sel_none;

  // zero wait states keep the read-to-clear window to one known cycle
  assign pready = 1'b1;

  // ------------------------------------------------------------ divider
  logic [6:0] count;
  evt_t fall;
  wire logic restart = acc_wr & (sel == sel_restart) & pwdata[`CT_RESTART_BIT];

  tap_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .restart(restart),
    .count(count),
    .fall(fall)
  );

  // ------------------------------------------------------------ registers
  evt_t enable_q;
  evt_t enable_d;
  evt_t flags_q;
  evt_t flags_d;
  evt_t flag_clr;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic slverr_q;
  logic slverr_d;

  // the tap register has no write path at all
  assign enable_d = (acc_wr && sel == sel_enable) ? pwdata[2:0] : enable_q;

  // clear only the bits handed out in this read; a new edge always wins
  assign flag_clr = (acc_rd && sel == sel_flags) ? rdata_q[2:0] : 3'h0;
  assign flags_d = (flags_q & ~flag_clr) | fall;

  // read data is captured in setup so it stands through the access phase
  assign rdata_d = !setup ? rdata_q :
                   (sel == sel_tap) ? {28'h0000000, count[`CT_TAP_MSB:`CT_TAP_LSB]} :
                   (sel == sel_enable) ? {29'h00000000, enable_q} :
                   (sel == sel_flags) ? {29'h00000000, flags_q} :
                   32'h00000000;
  assign slverr_d = setup ? (sel == sel_none) : slverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `CT_ENABLE_RST;
      flags_q <= `CT_FLAGS_RST;
      rdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata = rdata_q;
  assign pslverr = slverr_q & access;

  // software should only touch enables with processor interrupts off
  assign timer_irq = |(flags_q & enable_q);

  // ------------------------------------------------------------ checks
  property p_tap_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && sel == sel_tap) |=> (prdata == {28'h0000000, $past(count[6:3])});
  endproperty
  a_tap_read: assert property (p_tap_read) else $error("tap read data wrong");

  property p_tap_write;
    @(posedge pclk) disable iff (!presetn)
    (acc_wr && sel == sel_tap && !tick) |=> (count == $past(count));
  endproperty
  a_tap_write: assert property (p_tap_write) else $error("tap write disturbed counter");

  property p_reset_clear;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (count == 7'h00 && enable_q == 3'h0 && flags_q == 3'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    (acc_wr && sel == sel_enable) |=> (enable_q == $past(pwdata[2:0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_enable_hold;
    @(posedge pclk) disable iff (!presetn)
    !(acc_wr && sel == sel_enable) |=> $stable(enable_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed unasked");

  property p_flag_write;
    @(posedge pclk) disable iff (!presetn)
    (acc_wr && sel == sel_flags && fall == 3'h0) |=> $stable(flags_q);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write had effect");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    fall[0] |=> flags_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("32 Hz flag not set");

  // the 2 Hz edge is the wrap, where all three stages fall together
  property p_flag_set_2hz;
    @(posedge pclk) disable iff (!presetn)
    (fall[2] && !(acc_wr && sel == sel_enable))
      |=> (flags_q == 3'h7 && timer_irq == (|enable_q));
  endproperty
  a_flag_set_2hz: assert property (p_flag_set_2hz) else $error("2 Hz wrap event wrong");

  property p_read_clear;
    @(posedge pclk) disable iff (!presetn)
    (acc_rd && sel == sel_flags && fall == 3'h0 && prdata[2:0] == flags_q)
      |=> (flags_q == 3'h0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

  property p_flags_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !timer_irq;
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("irq after reset");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (acc_wr && sel == sel_restart && pwdata[0]) |=> (count == 7'h00);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear counter");

  property p_restart_zero;
    @(posedge pclk) disable iff (!presetn)
    (acc_wr && sel == sel_restart && !pwdata[0] && !tick) |=> (count == $past(count));
  endproperty
  a_restart_zero: assert property (p_restart_zero) else $error("zero restart acted");

  property p_restart_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && sel == sel_restart) |=> (prdata == 32'h00000000);
  endproperty
  a_restart_read: assert property (p_restart_read) else $error("restart read nonzero");

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup && (sel == sel_enable || sel == sel_flags)) |=> (prdata[31:3] == 29'h00000000);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (fall[1] && enable_q[1] && !(acc_wr && sel == sel_enable)) |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled 8 Hz event raised no irq");

  property p_divider_taps;
    @(posedge pclk) disable iff (!presetn)
    (tick && !restart) |=> (count == 7'($past(count) + 7'h01));
  endproperty
  a_divider_taps: assert property (p_divider_taps) else $error("tick did not advance taps");

  // tick and restart behaviour, read data and flag bookkeeping as seen from the bus
  property p_tick_once;
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("double tick");

  property p_restart_quiet;
    @(posedge pclk) disable iff (!presetn)
    restart |-> (fall == 3'h0);
  endproperty
  a_restart_quiet: assert property (p_restart_quiet) else $error("restart raised event");

  property p_flag_set_8hz;
    @(posedge pclk) disable iff (!presetn)
    fall[1] |=> flags_q[1];
  endproperty
  a_flag_set_8hz: assert property (p_flag_set_8hz) else $error("8 Hz flag not set");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    (fall == 3'h0 && !(acc_rd && sel == sel_flags)) |=> $stable(flags_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flags moved unasked");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (acc_rd && sel == sel_flags && fall[0]) |=> flags_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("read clear beat new event");

  property p_flags_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && sel == sel_flags) |=> (prdata[2:0] == $past(flags_q));
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read data wrong");

  property p_enable_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && sel == sel_enable) |=> (prdata[2:0] == $past(enable_q));
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read data wrong");

  property p_unmapped_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && sel == sel_none) |=> (prdata == 32'h00000000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

  property p_irq_on_enable;
    @(posedge pclk) disable iff (!presetn)
    (acc_wr && sel == sel_enable && (flags_q & pwdata[2:0]) != 3'h0) |=> timer_irq;
  endproperty
  a_irq_on_enable: assert property (p_irq_on_enable) else $error("enable gave no irq");

  property p_prdata_hold;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable) |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");

endmodule : clock_timer_control
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking testbench of the clock timer control block
`timescale 1ns/1ps
`default_nettype none
`include "clock_timer_regs.svh"
`define CHECK(name, exp, got) \
  begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %h seen %h", name, exp, got); end end
module testbench
  import clock_timer_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic src_256hz = 1'b0;
  logic timer_irq;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [6:0] cnt = 7'h00;
  logic [31:0] rd;
  logic err;
  localparam logic [11:0] tap_a = {`CT_IDX_TAP_DATA, 2'b00};
  localparam logic [11:0] ena_a = {`CT_IDX_IRQ_ENABLE, 2'b00};
  localparam logic [11:0] flg_a = {`CT_IDX_EVENT_FLAGS, 2'b00};
  localparam logic [11:0] rst_a = {`CT_IDX_RESTART, 2'b00};

  clock_timer_control i_clock_timer_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_256hz(src_256hz),
    .timer_irq(timer_irq)
  );

  always #5 pclk = ~pclk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // the whole run needs about 2550 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a hang here
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // k 256 Hz periods, each held long enough for the synchroniser
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge pclk) src_256hz <= 1'b1;
      repeat (8) @(posedge pclk);
      src_256hz <= 1'b0;
      repeat (8) @(posedge pclk);
      cnt = cnt + 7'h01;
    end
  endtask : ticks

  task automatic t_reset();
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHECK("irq in reset", 1'b0, timer_irq)
    presetn <= 1'b1;
    cnt = 7'h00;
    apb(0, tap_a, 0);
    `CHECK("tap reset", 32'h0, rd)
    apb(0, ena_a, 0);
    `CHECK("enable reset", 32'h0, rd)
    apb(0, flg_a, 0);
    `CHECK("flags reset", 32'h0, rd)
  endtask : t_reset

  task automatic t_regs();
    apb(1, ena_a, 32'hf);
    apb(0, ena_a, 0);
    `CHECK("enable rw", 32'h7, rd)
    apb(1, ena_a, 32'h0);
    apb(0, ena_a, 0);
    `CHECK("enable mask", 32'h0, rd)
    apb(0, rst_a, 0);
    `CHECK("restart read", 32'h0, rd)
    apb(0, 12'h000, 0);
    `CHECK("unmapped err", 1'b1, err)
    `CHECK("unmapped data", 32'h0, rd)
  endtask : t_regs

  task automatic t_tap();
    ticks(8);
    apb(0, tap_a, 0);
    `CHECK("tap after 8", 32'h1, rd)
    apb(1, tap_a, 32'hf);
    apb(0, tap_a, 0);
    `CHECK("tap write ignored", 32'h1, rd)
    `CHECK("irq masked", 1'b0, timer_irq)
    apb(1, flg_a, 32'h0);
    apb(0, flg_a, 0);
    `CHECK("flag 32hz", 32'h1, rd)
    apb(0, flg_a, 0);
    `CHECK("flag cleared", 32'h0, rd)
  endtask : t_tap

  task automatic t_irq();
    apb(1, ena_a, 32'h3);
    ticks(24);
    `CHECK("irq raised", 1'b1, timer_irq)
    apb(0, tap_a, 0);
    `CHECK("tap at 32", 32'(cnt[6:3]), rd)
    apb(0, flg_a, 0);
    `CHECK("flags 32 8", 32'h3, rd)
    @(posedge pclk);
    `CHECK("irq after clear", 1'b0, timer_irq)
    // only 2 Hz enabled: the 32 and 8 Hz flags must not raise the irq
    apb(1, ena_a, 32'h4);
    ticks(95);
    `CHECK("irq masked 32 8", 1'b0, timer_irq)
    ticks(1);
    `CHECK("irq 2hz", 1'b1, timer_irq)
    apb(1, ena_a, 32'h0);
    @(posedge pclk);
    `CHECK("irq masked off", 1'b0, timer_irq)
    apb(0, flg_a, 0);
    `CHECK("flags all", 32'h7, rd)
  endtask : t_irq

  task automatic t_restart();
    ticks(8);
    apb(1, rst_a, 32'h0);
    apb(0, tap_a, 0);
    `CHECK("restart zero", 32'(cnt[6:3]), rd)
    apb(1, rst_a, 32'h1);
    cnt = 7'h00;
    apb(0, tap_a, 0);
    `CHECK("restart one", 32'h0, rd)
    ticks(8);
    apb(0, tap_a, 0);
    `CHECK("resumed", 32'h1, rd)
  endtask : t_restart

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_tap();
    t_irq();
    t_restart();
    apb(1, ena_a, 32'h7);
    @(posedge pclk);
    `CHECK("irq on enable", 1'b1, timer_irq)
    // second reset in mid-run must clear everything again
    t_reset();
    conclude();
  end
endmodule : testbench
`default_nettype wire
